//--- core/rsq_pkg.sv
// constants, types and helpers for the regulator enable sequencer
// How it works
// - boost gating field picks bit-only or bit AND pin
// - boost off when enable bit clear
// - discharge bit connects resistor, resets to one
// - step-down 0 start waits programmed 0.5 ms steps
// - step-down 0 stop waits programmed shutdown steps
// - step-down 1 start waits programmed 0.5 ms steps
// - step-down 1 stop waits programmed shutdown steps
// - scale select makes every step 1 ms
// - boost enable, pin and voltage fields load defaults from one-time memory
package rsq_pkg;

  // register offsets
  localparam logic [7:0] RSQ_BOOST_CONTROL_OFS     = 8'h08;
  localparam logic [7:0] RSQ_STEP_DOWN0_DELAYS_OFS = 8'h09;
  localparam logic [7:0] RSQ_STEP_DOWN1_DELAYS_OFS = 8'h0A;

  // reset values
  localparam logic [7:0] RSQ_BOOST_CONTROL_RST     = 8'h08;
  localparam logic [7:0] RSQ_STEP_DOWN_DELAYS_RST  = 8'h00;
  localparam logic [7:0] RSQ_RDATA_UNMAPPED        = 8'h00;

  // boost_control fields
  localparam int RSQ_BOOST_EN_BIT        = 0;
  localparam int RSQ_BOOST_PIN_LSB       = 1;
  localparam int RSQ_BOOST_PIN_MSB       = 2;
  localparam int RSQ_BOOST_DISCHARGE_BIT = 3;
  localparam int RSQ_BOOST_VSET_LSB      = 6;
  localparam int RSQ_BOOST_VSET_MSB      = 7;

  // step_downN_delays fields
  localparam int RSQ_ON_DELAY_LSB  = 0;
  localparam int RSQ_ON_DELAY_MSB  = 3;
  localparam int RSQ_OFF_DELAY_LSB = 4;
  localparam int RSQ_OFF_DELAY_MSB = 7;

  // pin gating selections
  localparam logic [1:0] RSQ_GATE_NONE = 2'h0;
  localparam logic [1:0] RSQ_GATE_PIN1 = 2'h1;
  localparam logic [1:0] RSQ_GATE_PIN2 = 2'h2;
  localparam logic [1:0] RSQ_GATE_PIN3 = 2'h3;

  // timing
  localparam int unsigned RSQ_CLK_PERIOD_NS = 100;
  localparam int unsigned RSQ_STEP_NS       = 500_000;
  localparam int unsigned RSQ_STEP_CYCLES   = RSQ_STEP_NS / RSQ_CLK_PERIOD_NS;
  localparam int          RSQ_CYC_W         = 13;
  localparam int          RSQ_STEPS_W       = 5;

  typedef struct packed {
    logic                   active;
    logic                   prev;
    logic                   pending;
    logic [RSQ_STEPS_W-1:0] steps;
    logic [RSQ_CYC_W-1:0]   cyc;
  } rsq_seq_st_t;

  typedef struct packed {
    logic       otp_done;
    logic [7:0] boost_control;
    logic [7:0] sd0_delays;
    logic [7:0] sd1_delays;
    logic [7:0] rdata;
    logic       boost_on;
    logic       discharge;
  } rsq_top_st_t;

  // enable bit, optionally ANDed with one enable pin
  function automatic logic rsq_gate(input logic en, input logic [1:0] sel, input logic [3:1] pins);
    logic g;
    g = en;
    unique case (sel)
      RSQ_GATE_NONE: g = en;
      RSQ_GATE_PIN1: g = en & pins[1];
      RSQ_GATE_PIN2: g = en & pins[2];
      RSQ_GATE_PIN3: g = en & pins[3];
    endcase
    return g;
  endfunction : rsq_gate

endpackage : rsq_pkg

//--- core/rsq_delay_seq.sv
// start-up and shutdown delay timer for one converter
`timescale 1ns/1ps
`default_nettype none
module rsq_delay_seq
  import rsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = RSQ_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // control
  input  wire logic       ctrl_i,
  input  wire logic       scale_sel_i,
  input  wire logic [3:0] on_code_i,
  input  wire logic [3:0] off_code_i,
  // result
  output logic            active_o
);

  localparam logic [RSQ_CYC_W-1:0]   CYC_LAST  = RSQ_CYC_W'(TICK_CYCLES - 1);
  localparam logic [RSQ_STEPS_W-1:0] STEP_ONE  = 5'h01;

  rsq_seq_st_t st_reg;
  rsq_seq_st_t st_next;
  logic        edge_seen;
  logic [3:0]  sel_code;

  assign edge_seen = (ctrl_i != st_reg.prev);
  assign sel_code  = ctrl_i ? on_code_i : off_code_i;
  assign active_o  = st_reg.active;

  always_comb
  begin
    st_next = st_reg;
    if (edge_seen)
    begin
      // any change restarts the wait from zero
      st_next.prev  = ctrl_i;
      st_next.cyc   = '0;
      st_next.steps = scale_sel_i ? {sel_code, 1'b0} : {1'b0, sel_code};
      if (sel_code == 4'h0)
      begin
        st_next.active  = ctrl_i;
        st_next.pending = 1'b0;
      end
      else
      begin
        st_next.pending = 1'b1;
      end
    end
    else if (st_reg.pending)
    begin
      if (st_reg.cyc == CYC_LAST)
      begin
        st_next.cyc   = '0;
        st_next.steps = st_reg.steps - STEP_ONE;
        if (st_reg.steps == STEP_ONE)
        begin
          st_next.active  = st_reg.prev;
          st_next.pending = 1'b0;
        end
      end
      else
      begin
        st_next.cyc = st_reg.cyc + RSQ_CYC_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  chk_on_zero_delay: assert property (edge_seen && ctrl_i && on_code_i == 4'h0 |=> active_o)
    else $error("zero start-up delay did not switch on next cycle");
  chk_off_zero_delay: assert property (edge_seen && !ctrl_i && off_code_i == 4'h0 |=> !active_o)
    else $error("zero shutdown delay did not switch off next cycle");
  chk_hold_while_pending: assert property (
    st_reg.pending && !edge_seen && !(st_reg.cyc == CYC_LAST && st_reg.steps == STEP_ONE)
    |=> $stable(active_o))
    else $error("output changed before delay expired");
  chk_scale_step_count: assert property (
    edge_seen && scale_sel_i |=> st_reg.steps == {$past(sel_code), 1'b0})
    else $error("scaled delay loaded wrong step count");
  chk_restart_on_edge: assert property (
    edge_seen && sel_code != 4'h0 |=> st_reg.pending && st_reg.cyc == '0 && $stable(active_o))
    else $error("delay did not restart on control change");

endmodule : rsq_delay_seq
`default_nettype wire

//--- core/rsq_sequencer.sv
// boost control and step-down enable sequencing registers
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer
  import rsq_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = RSQ_STEP_CYCLES
)
(
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // one-time memory defaults for boost_control
  input  wire logic [7:0] otp_boost_control_i,
  // enable input pins
  input  wire logic       enable_input_1_i,
  input  wire logic       enable_input_2_i,
  input  wire logic       enable_input_3_i,
  // configuration and step-down enables kept elsewhere
  input  wire logic       delay_scale_sel_i,
  input  wire logic       step_down0_en_i,
  input  wire logic [1:0] step_down0_pin_sel_i,
  input  wire logic       step_down1_en_i,
  input  wire logic [1:0] step_down1_pin_sel_i,
  // converter controls
  output logic            boost_on_o,
  output logic            boost_discharge_on_o,
  output logic      [1:0] boost_vset_o,
  output logic            step_down_0_on_o,
  output logic            step_down_1_on_o
);

  rsq_top_st_t st_reg;
  rsq_top_st_t st_next;
  logic [3:1]  pins;
  logic        boost_ctrl;
  logic        sd0_ctrl;
  logic        sd1_ctrl;

  assign pins = {enable_input_3_i, enable_input_2_i, enable_input_1_i};

  // effective control signals
  assign boost_ctrl = rsq_gate(st_reg.boost_control[RSQ_BOOST_EN_BIT],
                               st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB], pins);
  assign sd0_ctrl   = rsq_gate(step_down0_en_i, step_down0_pin_sel_i, pins);
  assign sd1_ctrl   = rsq_gate(step_down1_en_i, step_down1_pin_sel_i, pins);

  always_comb
  begin
    st_next = st_reg;
    if (!st_reg.otp_done)
    begin
      // first cycle after release: pull in one-time defaults
      st_next.otp_done = 1'b1;
      st_next.boost_control[RSQ_BOOST_VSET_MSB:RSQ_BOOST_VSET_LSB] =
        otp_boost_control_i[RSQ_BOOST_VSET_MSB:RSQ_BOOST_VSET_LSB];
      st_next.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB] =
        otp_boost_control_i[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB];
      st_next.boost_control[RSQ_BOOST_EN_BIT] = otp_boost_control_i[RSQ_BOOST_EN_BIT];
    end
    else if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        RSQ_BOOST_CONTROL_OFS:     st_next.boost_control = reg_wdata_i;
        RSQ_STEP_DOWN0_DELAYS_OFS: st_next.sd0_delays    = reg_wdata_i;
        RSQ_STEP_DOWN1_DELAYS_OFS: st_next.sd1_delays    = reg_wdata_i;
        default:                   st_next.sd0_delays    = st_reg.sd0_delays;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        RSQ_BOOST_CONTROL_OFS:     st_next.rdata = st_reg.boost_control;
        RSQ_STEP_DOWN0_DELAYS_OFS: st_next.rdata = st_reg.sd0_delays;
        RSQ_STEP_DOWN1_DELAYS_OFS: st_next.rdata = st_reg.sd1_delays;
        default:                   st_next.rdata = RSQ_RDATA_UNMAPPED;
      endcase
    end
    st_next.boost_on  = boost_ctrl;
    st_next.discharge = st_reg.boost_control[RSQ_BOOST_DISCHARGE_BIT];
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      st_reg               <= '0;
      st_reg.boost_control <= RSQ_BOOST_CONTROL_RST;
      st_reg.sd0_delays    <= RSQ_STEP_DOWN_DELAYS_RST;
      st_reg.sd1_delays    <= RSQ_STEP_DOWN_DELAYS_RST;
      st_reg.discharge     <= RSQ_BOOST_CONTROL_RST[RSQ_BOOST_DISCHARGE_BIT];
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o          = st_reg.rdata;
  assign boost_on_o           = st_reg.boost_on;
  assign boost_discharge_on_o = st_reg.discharge;
  assign boost_vset_o         = st_reg.boost_control[RSQ_BOOST_VSET_MSB:RSQ_BOOST_VSET_LSB];

  // step-down 0 timing
  rsq_delay_seq #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_step_down0_seq (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .ctrl_i      (sd0_ctrl),
    .scale_sel_i (delay_scale_sel_i),
    .on_code_i   (st_reg.sd0_delays[RSQ_ON_DELAY_MSB:RSQ_ON_DELAY_LSB]),
    .off_code_i  (st_reg.sd0_delays[RSQ_OFF_DELAY_MSB:RSQ_OFF_DELAY_LSB]),
    .active_o    (step_down_0_on_o)
  );

  // step-down 1 timing
  rsq_delay_seq #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_step_down1_seq (
    .clk_sys_i   (clk_sys_i),
    .arst_n_i    (arst_n_i),
    .ctrl_i      (sd1_ctrl),
    .scale_sel_i (delay_scale_sel_i),
    .on_code_i   (st_reg.sd1_delays[RSQ_ON_DELAY_MSB:RSQ_ON_DELAY_LSB]),
    .off_code_i  (st_reg.sd1_delays[RSQ_OFF_DELAY_MSB:RSQ_OFF_DELAY_LSB]),
    .active_o    (step_down_1_on_o)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_pin_gated_low;
    st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB] != RSQ_GATE_NONE &&
    !pins[st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB]];
  endsequence

  sequence s_bit_only_on;
    st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB] == RSQ_GATE_NONE &&
    st_reg.boost_control[RSQ_BOOST_EN_BIT];
  endsequence

  chk_boost_pin_gate: assert property (s_pin_gated_low |=> !boost_on_o)
    else $error("boost on while selected enable pin low");
  chk_boost_bit_only: assert property (s_bit_only_on |=> boost_on_o)
    else $error("boost off with bit-only control and bit set");
  chk_boost_bit_off: assert property (!st_reg.boost_control[RSQ_BOOST_EN_BIT] |=> !boost_on_o)
    else $error("boost on while enable bit clear");
  chk_discharge_follow: assert property (
    st_reg.otp_done |=> boost_discharge_on_o == $past(st_reg.boost_control[RSQ_BOOST_DISCHARGE_BIT]))
    else $error("discharge output does not follow its bit");
  chk_otp_defaults: assert property (
    !st_reg.otp_done |=> st_reg.boost_control[2:0] == $past(otp_boost_control_i[2:0]) &&
    boost_vset_o == $past(otp_boost_control_i[7:6]) && st_reg.boost_control[5:3] == 3'h1)
    else $error("boost defaults not loaded from one-time memory");
  chk_unmapped_read: assert property (
    reg_rd_i && reg_addr_i > RSQ_STEP_DOWN1_DELAYS_OFS |=> reg_rdata_o == RSQ_RDATA_UNMAPPED)
    else $error("unmapped read returned nonzero");

  // register port behaviour
  chk_write_boost_reg: assert property (
    st_reg.otp_done && reg_wr_i && reg_addr_i == RSQ_BOOST_CONTROL_OFS
    |=> st_reg.boost_control == $past(reg_wdata_i))
    else $error("boost_control write did not land");
  chk_vset_follow: assert property (
    st_reg.otp_done && reg_wr_i && reg_addr_i == RSQ_BOOST_CONTROL_OFS
    |=> boost_vset_o == $past(reg_wdata_i[RSQ_BOOST_VSET_MSB:RSQ_BOOST_VSET_LSB]))
    else $error("boost voltage code does not follow its field");
  chk_write_sd0_reg: assert property (
    st_reg.otp_done && reg_wr_i && reg_addr_i == RSQ_STEP_DOWN0_DELAYS_OFS
    |=> st_reg.sd0_delays == $past(reg_wdata_i))
    else $error("step_down0_delays write did not land");
  chk_write_sd1_reg: assert property (
    st_reg.otp_done && reg_wr_i && reg_addr_i == RSQ_STEP_DOWN1_DELAYS_OFS
    |=> st_reg.sd1_delays == $past(reg_wdata_i))
    else $error("step_down1_delays write did not land");
  chk_unmapped_write: assert property (
    st_reg.otp_done && reg_wr_i && reg_addr_i > RSQ_STEP_DOWN1_DELAYS_OFS
    |=> $stable(st_reg.boost_control) && $stable(st_reg.sd0_delays) && $stable(st_reg.sd1_delays))
    else $error("unmapped write changed a register");
  chk_otp_load_once: assert property (
    st_reg.otp_done |=> st_reg.otp_done)
    else $error("one-time defaults loaded again");

  // read data stands until the next read
  chk_read_boost_reg: assert property (
    reg_rd_i && reg_addr_i == RSQ_BOOST_CONTROL_OFS |=> reg_rdata_o == $past(st_reg.boost_control))
    else $error("boost_control read returned wrong data");
  chk_read_sd0_reg: assert property (
    reg_rd_i && reg_addr_i == RSQ_STEP_DOWN0_DELAYS_OFS |=> reg_rdata_o == $past(st_reg.sd0_delays))
    else $error("step_down0_delays read returned wrong data");
  chk_read_sd1_reg: assert property (
    reg_rd_i && reg_addr_i == RSQ_STEP_DOWN1_DELAYS_OFS |=> reg_rdata_o == $past(st_reg.sd1_delays))
    else $error("step_down1_delays read returned wrong data");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  // selected pin high passes the enable bit through
  sequence s_pin_gated_high;
    st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB] != RSQ_GATE_NONE &&
    pins[st_reg.boost_control[RSQ_BOOST_PIN_MSB:RSQ_BOOST_PIN_LSB]] && st_reg.boost_control[RSQ_BOOST_EN_BIT];
  endsequence

  chk_boost_pin_pass: assert property (s_pin_gated_high |=> boost_on_o)
    else $error("boost off while bit set and selected pin high");

  // a low selected pin keeps a stopped step-down stopped
  chk_sd0_pin_gate: assert property (
    step_down0_pin_sel_i != RSQ_GATE_NONE && !pins[step_down0_pin_sel_i] && !step_down_0_on_o
    |=> !step_down_0_on_o)
    else $error("step-down 0 started while its selected pin low");
  chk_sd1_pin_gate: assert property (
    step_down1_pin_sel_i != RSQ_GATE_NONE && !pins[step_down1_pin_sel_i] && !step_down_1_on_o
    |=> !step_down_1_on_o)
    else $error("step-down 1 started while its selected pin low");

endmodule : rsq_sequencer
`default_nettype wire

//--- verification/rsq_host_model.sv
// host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module rsq_host_model
(
  // clock
  input  wire logic       clk_sys_i,
  // register port
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i
);
  initial
  begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end

  // released lines show the inverse of the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_sys_i);
    #1;
    d = reg_rdata_i;
  endtask : rd
endmodule : rsq_host_model
`default_nettype wire

//--- verification/rsq_sequencer_test.sv
// self-checking bench for the enable sequencer
`timescale 1ns/1ps
`default_nettype none
module rsq_sequencer_test;
  import rsq_pkg::*;
  localparam int unsigned TICK = 4;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, otp, d, v;
  logic reg_wr, reg_rd, pin1, pin2, pin3, scale, sd0_en, sd1_en, b_on, b_dis, sd0_on, sd1_on;
  logic [1:0] sd0_sel, sd1_sel, vset;
  int errors = 0;
  int num_checks = 0;
  int seed = 34;
  int cyc = 0;
  wire logic [1:0] sd_on = {sd1_on, sd0_on};

  always #50 clk_sys_i = ~clk_sys_i;

  rsq_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

  rsq_sequencer #(.TICK_CYCLES(TICK)) uut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .otp_boost_control_i(otp), .enable_input_1_i(pin1),
    .enable_input_2_i(pin2), .enable_input_3_i(pin3), .delay_scale_sel_i(scale),
    .step_down0_en_i(sd0_en), .step_down0_pin_sel_i(sd0_sel), .step_down1_en_i(sd1_en),
    .step_down1_pin_sel_i(sd1_sel), .boost_on_o(b_on), .boost_discharge_on_o(b_dis),
    .boost_vset_o(vset), .step_down_0_on_o(sd0_on), .step_down_1_on_o(sd1_on));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  function automatic logic exp_boost(input logic [7:0] r, input logic [3:1] p);
    return r[0] & (r[2:1] == 2'h0 ? 1'b1 : p[r[2:1]]);
  endfunction : exp_boost

  function automatic int exp_wait(input logic [3:0] c, input logic s);
    return 1 + int'(c) * (s ? 2 : 1) * TICK;
  endfunction : exp_wait

  // toggle one converter's enable and count edges until its output follows
  task automatic sd_step(input int i, input logic lvl, input logic [3:0] c, input logic s);
    int n;
    @(posedge clk_sys_i);
    scale <= s;
    if (i == 0) sd0_en <= lvl;
    else sd1_en <= lvl;
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end
    while (sd_on[i] !== lvl && n < 200);
    check(8'(n), 8'(exp_wait(c, s)));
  endtask : sd_step

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end

  initial
  begin
    otp = 8'($random(seed));
    {pin1, pin2, pin3, scale, sd0_en, sd1_en} = 6'h00;
    sd0_sel = 2'h0;
    sd1_sel = 2'h0;
    repeat (5) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    host.rd(RSQ_BOOST_CONTROL_OFS, d);
    check(d, (otp & 8'hC7) | 8'h08);
    check({7'h00, b_dis}, 8'h01);
    for (int a = 9; a < 12; a++)
    begin
      host.rd(8'(a), d);
      check(d, 8'h00);
    end
    for (int i = 0; i < 16; i++)
    begin
      v = $random(seed);
      v[2:1] = i[1:0];
      host.wr(RSQ_BOOST_CONTROL_OFS, v);
      @(posedge clk_sys_i);
      {pin3, pin2, pin1} <= 3'($random(seed));
      repeat (3) @(posedge clk_sys_i);
      #1;
      check({7'h00, b_on}, {7'h00, exp_boost(v, {pin3, pin2, pin1})});
      check({5'h00, b_dis, vset}, {5'h00, v[3], v[7:6]});
    end
    host.wr(8'h0B, 8'hFF);
    host.rd(8'h0B, d);
    check(d, 8'h00);
    @(posedge clk_sys_i);
    {pin3, pin2, pin1} <= 3'h7;
    for (int k = 0; k < 8; k++)
    begin
      for (int i = 0; i < 2; i++)
      begin
        v = (k == 0) ? 8'hF0 : 8'($random(seed));
        host.wr(8'(9 + i), v);
        host.rd(8'(9 + i), d);
        check(d, v);
        sd0_sel <= 2'($random(seed));
        sd1_sel <= 2'($random(seed));
        sd_step(i, 1'b1, v[3:0], k[0]);
        sd_step(i, 1'b0, v[7:4], k[1]);
      end
    end
    // control returns to the output level mid-wait
    host.wr(RSQ_STEP_DOWN0_DELAYS_OFS, 8'h02);
    @(posedge clk_sys_i);
    scale <= 1'b0;
    sd0_en <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    sd0_en <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1;
    check({7'h00, sd0_on}, 8'h00);
    sd_step(0, 1'b1, 4'h2, 1'b0);
    // selected pin gates step-down 0: pin low stops it, pin high starts the wait
    host.wr(RSQ_STEP_DOWN0_DELAYS_OFS, 8'h01);
    @(posedge clk_sys_i);
    sd0_sel <= 2'h1;
    pin1 <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    check({7'h00, sd0_on}, 8'h00);
    @(posedge clk_sys_i);
    pin1 <= 1'b1;
    repeat (TICK) @(posedge clk_sys_i);
    #1;
    check({7'h00, sd0_on}, 8'h00);
    @(posedge clk_sys_i);
    #1;
    check({7'h00, sd0_on}, 8'h01);
    summarize();
  end
endmodule : rsq_sequencer_test
`default_nettype wire
